/* File: hw/dsf_defs.vh */
// Register indices, field positions and reset values of the config bank
`ifndef DSF_DEFS_VH
`define DSF_DEFS_VH
`define DSF_IDX_DMA_SEL 8'h74
`define DSF_IDX_FDD_MODE 8'hf0
`define DSF_IDX_FDD_OPT 8'hf1
`define DSF_IDX_FDD_TYPE 8'hf2
`define DSF_IDX_RSVD 8'hf3
`define DSF_IDX_DRV0 8'hf4
`define DSF_IDX_DRV1 8'hf5
`define DSF_RST_DMA_SEL 3'h4
`define DSF_RST_FDD_MODE 8'h0e
`define DSF_RST_FDD_OPT 8'h00
`define DSF_RST_FDD_TYPE 8'hff
`define DSF_RST_DRV 8'h00
`define DSF_MASK_DMA_SEL 8'h07
`define DSF_MASK_FDD_MODE 8'hdf
`define DSF_MASK_FDD_OPT 8'hcc
`define DSF_MASK_DRV 8'h5b
`define DSF_MODE_ENH 0
`define DSF_MODE_NONBURST 1
`define DSF_MODE_IF_LO 2
`define DSF_MODE_SWAP 4
`define DSF_MODE_PUSHPULL 6
`define DSF_MODE_TRIST 7
`define DSF_OPT_DENS_LO 2
`define DSF_OPT_BOOT_LO 6
`define DSF_DRV_PRECOMP 6
`define DSF_DENS_FORCE1 2'h2
`define DSF_DENS_FORCE0 2'h3
`define DSF_BOOT_DRV1 2'h1
`endif

/* File: hw/dsf_config_bank.v */
// DMA select, IRQ/DMA output gating and floppy vendor config registers
// Behaviour
// R1: DMA select bits 2:0, 4-7 none
// R2: Channel active needs select 0-3 and owner enable
// R3: Unused DMA request pins float
// R4: Device-local disable adds to config disable
// R5: Floppy IRQ/DACK float, request ignored when gated
// R6: UART irq floats while modem control bit2 zero
// R7: Parallel SPP/EPP irq follows control bit four
// R8: ECP mode: DMA follows enable, irq table
// R9: Vendor registers reset only by hard reset
// R10: Mode bit0 enhanced, bit1 non-burst DMA
// R11: Mode bits 3:2 select interface mode
// R12: Mode bit4 swaps drive/motor selects 0,1
// R13: Mode bit6 push-pull, bit7 tristates outputs
// R14: Option bits 3:2 force density output
// R15: Option bits 7:6 choose boot drive
// R16: Type register holds A, B, spare storage
// R17: Index f3 reads zero always
// R18: Drive zero: type, rate table, zero bits
// R19: Drive bit6 disables write precompensation
// R20: Drive one same layout as zero
// R21: Reserved bits ignore writes, read zero
`timescale 1ns/1ps
`include "dsf_defs.vh"
module dsf_config_bank (
    input wire clk,
    input wire sys_rst,
    input wire soft_rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire cfg_active,
    input wire addr_valid,
    input wire floppy_dma_gate,
    input wire floppy_powerdown,
    input wire floppy_irq,
    input wire floppy_dack,
    input wire floppy_dreq,
    input wire [1:0] modem_control_reg_uart_irq_gate,
    input wire [1:0] uart_irq,
    input wire uart2_dma_gate,
    input wire uart2_dreq,
    input wire uart2_dack,
    input wire par_ecp_mode,
    input wire [2:0] par_ecr_mode,
    input wire parallel_irq_gate,
    input wire parallel_dma_gate,
    input wire par_irq,
    input wire par_dreq,
    input wire par_dack,
    input wire [1:0] fdc_drive_sel,
    input wire [1:0] fdc_motor_sel,
    input wire fdc_density,
    output wire [3:0] dma_request_pins_o,
    output wire [3:0] dma_request_pins_oe,
    output wire floppy_dack_out,
    output wire floppy_dack_oe,
    output wire floppy_irq_out,
    output wire floppy_irq_oe,
    output wire [1:0] uart_irq_out,
    output wire [1:0] uart_irq_oe,
    output wire par_irq_out,
    output wire par_irq_oe,
    output wire par_dack_out,
    output wire uart2_dack_out,
    output wire floppy_dreq_taken,
    output wire [1:0] drive_sel_out,
    output wire [1:0] motor_sel_out,
    output wire density_out,
    output wire floppy_out_oe,
    output wire floppy_push_pull,
    output wire floppy_enhanced,
    output wire floppy_non_burst,
    output wire [1:0] floppy_if_mode,
    output wire boot_drive_valid,
    output wire boot_drive,
    output wire [1:0] drive_type_sel0,
    output wire [1:0] drive_type_sel1,
    output wire [1:0] rate_table_sel0,
    output wire [1:0] rate_table_sel1,
    output wire [1:0] precomp_disable
);

reg [2:0] dma_sel_q;
reg [7:0] fdd_mode_q;
reg [7:0] fdd_opt_q;
reg [7:0] fdd_type_q;
reg [7:0] drv_q [0:1];
wire wr_dma = reg_wr && reg_addr == `DSF_IDX_DMA_SEL;
wire wr_mode = reg_wr && reg_addr == `DSF_IDX_FDD_MODE;
wire wr_opt = reg_wr && reg_addr == `DSF_IDX_FDD_OPT;
wire wr_type = reg_wr && reg_addr == `DSF_IDX_FDD_TYPE;

// Hard reset only; soft_rst deliberately has no effect here
always @(posedge clk) begin
    if (sys_rst) begin // R9
        dma_sel_q <= `DSF_RST_DMA_SEL;
        fdd_mode_q <= `DSF_RST_FDD_MODE;
        fdd_opt_q <= `DSF_RST_FDD_OPT;
        fdd_type_q <= `DSF_RST_FDD_TYPE;
    end else begin
        if (wr_dma) begin
            dma_sel_q <= reg_wdata[2:0]; // R1
        end
        if (wr_mode) begin
            fdd_mode_q <= reg_wdata & `DSF_MASK_FDD_MODE; // R21
        end
        if (wr_opt) begin
            fdd_opt_q <= reg_wdata & `DSF_MASK_FDD_OPT; // R21
        end
        if (wr_type) begin
            fdd_type_q <= reg_wdata; // R16
        end
    end
end

genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : g_drv
        always @(posedge clk) begin
            if (sys_rst) begin // R9
                drv_q[g] <= `DSF_RST_DRV; // R20
            end else if (reg_wr && reg_addr == `DSF_IDX_DRV0 + g) begin
                drv_q[g] <= reg_wdata & `DSF_MASK_DRV; // R18 R21
            end
        end
        assign precomp_disable[g] = drv_q[g][`DSF_DRV_PRECOMP]; // R19
    end
endgenerate

always @(posedge clk) begin
    if (sys_rst) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        if (reg_addr == `DSF_IDX_DMA_SEL) begin
            reg_rdata <= {5'h00, dma_sel_q};
        end else if (reg_addr == `DSF_IDX_FDD_MODE) begin
            reg_rdata <= fdd_mode_q;
        end else if (reg_addr == `DSF_IDX_FDD_OPT) begin
            reg_rdata <= fdd_opt_q;
        end else if (reg_addr == `DSF_IDX_FDD_TYPE) begin
            reg_rdata <= fdd_type_q;
        end else if (reg_addr == `DSF_IDX_DRV0) begin
            reg_rdata <= drv_q[0];
        end else if (reg_addr == `DSF_IDX_DRV1) begin
            reg_rdata <= drv_q[1];
        end else begin
            reg_rdata <= 8'h00; // R17
        end
    end
end

// Configuration-level enable shared by every logical device
wire cfg_ok = cfg_active && addr_valid; // R4
wire chan_ok = !dma_sel_q[2]; // R1
wire fdc_on = cfg_ok && floppy_dma_gate && !floppy_powerdown; // R5
wire par_dma_on = cfg_ok && par_ecp_mode && parallel_dma_gate; // R2 R8
wire u2_dma_on = cfg_ok && uart2_dma_gate; // R2
reg par_irq_on;
always @* begin
    if (!par_ecp_mode) begin
        par_irq_on = parallel_irq_gate; // R7
    end else begin
        case (par_ecr_mode)
            3'h2, 3'h3, 3'h6: par_irq_on = 1'b1; // R8
            default: par_irq_on = parallel_irq_gate; // R8
        endcase
    end
end

// Only one owner drives the selected channel
wire any_dma = chan_ok && (fdc_on || par_dma_on || u2_dma_on); // R2
wire req_val = fdc_on ? floppy_dreq : (par_dma_on ? par_dreq : uart2_dreq);
generate
    for (g = 0; g < 4; g = g + 1) begin : g_dreq
        assign dma_request_pins_oe[g] = any_dma && dma_sel_q[1:0] == g; // R3
        assign dma_request_pins_o[g] = req_val;
    end
    for (g = 0; g < 2; g = g + 1) begin : g_uirq
        assign uart_irq_oe[g] = cfg_ok && modem_control_reg_uart_irq_gate[g]; // R6
        assign uart_irq_out[g] = uart_irq[g];
    end
endgenerate

assign floppy_dreq_taken = fdc_on && chan_ok && floppy_dreq; // R5
assign floppy_dack_oe = fdc_on; // R5
assign floppy_dack_out = floppy_dack;
assign floppy_irq_oe = fdc_on; // R5
assign floppy_irq_out = floppy_irq;
assign par_irq_oe = cfg_ok && par_irq_on; // R4
assign par_irq_out = par_irq;
assign par_dack_out = par_dack && par_dma_on && chan_ok; // R4
assign uart2_dack_out = uart2_dack && u2_dma_on && chan_ok; // R4

wire swap = fdd_mode_q[`DSF_MODE_SWAP];
assign drive_sel_out = swap ? {fdc_drive_sel[0], fdc_drive_sel[1]}
                            : fdc_drive_sel; // R12
assign motor_sel_out = swap ? {fdc_motor_sel[0], fdc_motor_sel[1]}
                            : fdc_motor_sel; // R12
assign floppy_out_oe = !fdd_mode_q[`DSF_MODE_TRIST]; // R13
assign floppy_push_pull = fdd_mode_q[`DSF_MODE_PUSHPULL]; // R13
assign floppy_enhanced = fdd_mode_q[`DSF_MODE_ENH]; // R10
assign floppy_non_burst = fdd_mode_q[`DSF_MODE_NONBURST]; // R10
assign floppy_if_mode =
    fdd_mode_q[`DSF_MODE_IF_LO+1:`DSF_MODE_IF_LO]; // R11

wire [1:0] dens = fdd_opt_q[`DSF_OPT_DENS_LO+1:`DSF_OPT_DENS_LO];
assign density_out = dens == `DSF_DENS_FORCE1 ? 1'b1 :
                     dens == `DSF_DENS_FORCE0 ? 1'b0 : fdc_density; // R14
wire [1:0] boot = fdd_opt_q[`DSF_OPT_BOOT_LO+1:`DSF_OPT_BOOT_LO];
assign boot_drive_valid = !boot[1]; // R15
assign boot_drive = boot == `DSF_BOOT_DRV1; // R15

assign drive_type_sel0 = drv_q[0][1:0]; // R18
assign drive_type_sel1 = drv_q[1][1:0]; // R20
assign rate_table_sel0 = drv_q[0][4:3]; // R18
assign rate_table_sel1 = drv_q[1][4:3]; // R20

endmodule // dsf_config_bank

/* File: verification/dsf_config_bank_monitor.sv */
// Concurrent checks on the config bank ports
`timescale 1ns/1ps
module dsf_config_bank_monitor (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire floppy_dma_gate,
    input wire floppy_powerdown,
    input wire [1:0] modem_control_reg_uart_irq_gate,
    input wire [1:0] fdc_drive_sel,
    input wire [3:0] dma_request_pins_oe,
    input wire floppy_irq_oe,
    input wire floppy_dack_oe,
    input wire floppy_dreq_taken,
    input wire [1:0] uart_irq_oe,
    input wire [1:0] drive_sel_out,
    input wire floppy_out_oe,
    input wire density_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_wr(a, b);
        reg_wr && reg_addr == a && b;
    endsequence
    sequence s_wr_rd(a);
        s_wr(a, 1'b1) ##1 reg_rd && reg_addr == a;
    endsequence
    AST_RSVD_ZERO: assert property (
        reg_rd && reg_addr == 8'hf3 |=> reg_rdata == 8'h00)
        else $error("reserved index read nonzero");
    AST_DMA_SEL: assert property (
        s_wr_rd(8'h74) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h07))
        else $error("dma select readback");
    AST_DMA_NONE: assert property (
        s_wr(8'h74, reg_wdata[2]) |=> dma_request_pins_oe == 4'h0)
        else $error("dma request driven with no channel");
    AST_FDC_GATE: assert property (
        !floppy_dma_gate || floppy_powerdown |->
        !floppy_irq_oe && !floppy_dack_oe && !floppy_dreq_taken)
        else $error("floppy gate");
    AST_UART_GATE: assert property (
        (uart_irq_oe & ~modem_control_reg_uart_irq_gate) == 2'h0)
        else $error("uart irq driven while gated");
    AST_TRIST: assert property (
        s_wr(8'hf0, reg_wdata[7]) |=> !floppy_out_oe)
        else $error("floppy outputs not tristated");
    AST_SWAP: assert property (
        s_wr(8'hf0, reg_wdata[4]) |=>
        drive_sel_out == {fdc_drive_sel[0], fdc_drive_sel[1]})
        else $error("swap");
    AST_DENS: assert property (
        s_wr(8'hf1, reg_wdata[3:2] == 2'h2) |=> density_out)
        else $error("density not forced high");
endmodule // dsf_config_bank_monitor
bind dsf_config_bank dsf_config_bank_monitor u_mon (.clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .floppy_dma_gate, .floppy_powerdown,
    .modem_control_reg_uart_irq_gate, .fdc_drive_sel, .dma_request_pins_oe, .floppy_irq_oe,
    .floppy_dack_oe, .floppy_dreq_taken, .uart_irq_oe, .drive_sel_out,
    .floppy_out_oe, .density_out);

/* File: verification/dsf_host.sv */
// Register bus host model
`timescale 1ns/1ps
module dsf_host (
    input wire clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
    end
    task op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask
endmodule // dsf_host

/* File: verification/tb.sv */
// Self-checking bench for the config bank
`timescale 1ns/1ps
module tb;
    logic clk, sys_rst, soft_rst, reg_wr, reg_rd, cfg_active, addr_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic floppy_dma_gate, floppy_powerdown, floppy_irq, floppy_dack, floppy_dreq;
    logic uart2_dma_gate, uart2_dreq, uart2_dack, par_ecp_mode, par_dack;
    logic parallel_irq_gate, parallel_dma_gate, par_irq, par_dreq, fdc_density;
    logic floppy_dack_out, floppy_dack_oe, floppy_irq_out, floppy_irq_oe;
    logic par_irq_out, par_irq_oe, par_dack_out, uart2_dack_out, density_out;
    logic floppy_dreq_taken, floppy_out_oe, floppy_push_pull, floppy_enhanced;
    logic floppy_non_burst, boot_drive_valid, boot_drive;
    logic [1:0] modem_control_reg_uart_irq_gate, uart_irq, fdc_drive_sel, fdc_motor_sel;
    logic [1:0] uart_irq_out, uart_irq_oe, drive_sel_out, motor_sel_out;
    logic [1:0] floppy_if_mode, drive_type_sel0, drive_type_sel1;
    logic [1:0] rate_table_sel0, rate_table_sel1, precomp_disable;
    logic [2:0] par_ecr_mode;
    logic [3:0] dma_request_pins_o, dma_request_pins_oe;
    logic [31:0] seed = 32'h00010259;
    logic [27:0] pins = 28'h0;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic cfg_en, fdc_en;
    assign cfg_en = cfg_active && addr_valid;
    assign fdc_en = cfg_en && floppy_dma_gate && !floppy_powerdown;
    int n_fail = 0;
    int comparisons = 0;
    logic [7:0] ra[8] = '{8'h74, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'h75};
    logic [7:0] rv[8] = '{8'h04, 8'h0e, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] mk[8] = '{8'h07, 8'hdf, 8'hcc, 8'hff, 8'h00, 8'h5b, 8'h5b, 8'h00};
    assign {cfg_active, addr_valid, floppy_dma_gate, floppy_powerdown, floppy_irq,
        floppy_dack, floppy_dreq, modem_control_reg_uart_irq_gate, uart_irq, uart2_dma_gate,
        uart2_dreq, uart2_dack, par_ecp_mode, par_ecr_mode, parallel_irq_gate,
        parallel_dma_gate, par_irq, par_dreq, par_dack, fdc_drive_sel,
        fdc_motor_sel, fdc_density} = pins;
    dsf_config_bank u_dsf_config_bank (.*);
    dsf_host u_dsf_host (.*);
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic ok);
        comparisons++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t mismatch", $time);
        end
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_dsf_host.op(1'b0, 1'b1, a, 8'h00);
    endtask
    task test_done;
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        seed <= nx(seed);
        pins <= seed[27:0];
        if (rd_seen) begin
            chk(reg_rdata === exp_q.pop_front());
        end
        rd_seen = reg_rd;
        chk(uart_irq_oe === ({2{cfg_en}} & modem_control_reg_uart_irq_gate));
        chk(floppy_irq_oe === fdc_en && floppy_dack_oe === fdc_en);
        chk(par_ecp_mode || par_irq_oe === (cfg_en && parallel_irq_gate));
    end
    initial begin
        repeat (1000) @(posedge clk);
        n_fail++;
        test_done;
    end
    initial begin
        sys_rst = 1'b1;
        soft_rst = 1'b0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], rv[i]);
        end
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 8; i++) begin
                d = (k == 0) ? 8'hff : seed[15:8];
                u_dsf_host.op(1'b1, 1'b0, ra[i], d);
                rd(ra[i], d & mk[i]);
            end
        end
        u_dsf_host.op(1'b1, 1'b0, 8'hf0, 8'h10);
        u_dsf_host.op(1'b1, 1'b0, 8'hf1, 8'h88);
        u_dsf_host.op(1'b0, 1'b0, 8'h00, 8'h00);
        #1;
        chk(boot_drive_valid === 1'b0 && density_out === 1'b1);
        chk(floppy_if_mode === 2'h0 && floppy_out_oe === 1'b1);
        chk(motor_sel_out === {fdc_motor_sel[0], fdc_motor_sel[1]});
        @(posedge clk);
        soft_rst <= 1'b1;
        u_dsf_host.op(1'b0, 1'b0, 8'h00, 8'h00);
        soft_rst <= 1'b0;
        rd(8'hf0, 8'h10);
        u_dsf_host.op(1'b0, 1'b0, 8'h00, 8'h00);
        sys_rst <= 1'b1;
        u_dsf_host.op(1'b0, 1'b0, 8'h00, 8'h00);
        sys_rst <= 1'b0;
        rd(8'hf1, 8'h00);
        repeat (2) u_dsf_host.op(1'b0, 1'b0, 8'h00, 8'h00);
        #1;
        chk(floppy_if_mode === 2'h3 && floppy_non_burst === 1'b1);
        chk(dma_request_pins_oe === 4'h0 && boot_drive_valid === 1'b1);
        chk(precomp_disable === 2'h0 && floppy_push_pull === 1'b0);
        u_dsf_host.op(1'b1, 1'b0, 8'hf4, 8'h5b);
        u_dsf_host.op(1'b1, 1'b0, 8'hf5, 8'hff);
        u_dsf_host.op(1'b1, 1'b0, 8'hf0, 8'hc0);
        u_dsf_host.op(1'b1, 1'b0, 8'hf1, 8'h40);
        u_dsf_host.op(1'b0, 1'b0, 8'h00, 8'h00);
        #1;
        chk(drive_type_sel0 === 2'h3 && rate_table_sel0 === 2'h3);
        chk(precomp_disable === 2'h3 && rate_table_sel1 === 2'h3);
        chk(floppy_out_oe === 1'b0 && floppy_push_pull === 1'b1);
        chk(boot_drive === 1'b1 && density_out === fdc_density);
        test_done;
    end
endmodule // tb
